// ===== rtl/mac_pkg.sv
package mac_pkg;

  // ----------------------------------------------------------------
  // commands on the link
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CMD_NOP = 3'h0,
    CMD_READ = 3'h1,
    CMD_WRITE = 3'h2,
    CMD_REF = 3'h3,
    CMD_MRS = 3'h4
  } mac_cmd_e;

  // ----------------------------------------------------------------
  // geometry and mode word layout
  // ----------------------------------------------------------------
  localparam int BANK_W = 3;
  localparam int BANKS = 8;
  localparam int MUX_BIT = 5;
  localparam int CFG_LSB = 0;
  localparam int BL_LSB = 3;
  localparam int MAX_BEATS = 4;
  localparam int SLOTS = 16;
  localparam int MUX_EXTRA = 1;
  localparam int RD_PIPE = 2;
  localparam int WR_PIPE = 1;
  localparam int RSP_DEPTH = 2;
  localparam int FREQ_MIN_MHZ = 32'hAF;
  localparam logic [2:0] CFG_1 = 3'h0;
  localparam logic [2:0] CFG_2 = 3'h1;
  localparam logic [2:0] CFG_3 = 3'h2;
  localparam logic [2:0] CFG_4 = 3'h3;
  localparam logic [2:0] CFG_5 = 3'h4;
  localparam logic [1:0] BL_2 = 2'h0;
  localparam logic [1:0] BL_4 = 2'h1;
  localparam logic [1:0] BL_8 = 2'h2;

  typedef logic [3:0] mac_cyc_t;

  // ----------------------------------------------------------------
  // configuration tables, latencies in multiplexed addressing
  // ----------------------------------------------------------------
  function automatic mac_cyc_t trc_of(input logic [2:0] cfg);
    case (cfg)
      CFG_2: trc_of = 4'h6;
      CFG_3: trc_of = 4'h8;
      CFG_4: trc_of = 4'h3;
      CFG_5: trc_of = 4'h5;
      default: trc_of = 4'h4;
    endcase
  endfunction : trc_of

  function automatic mac_cyc_t rl_of(input logic [2:0] cfg);
    case (cfg)
      CFG_2: rl_of = 4'h7;
      CFG_3: rl_of = 4'h9;
      CFG_4: rl_of = 4'h4;
      CFG_5: rl_of = 4'h6;
      default: rl_of = 4'h5;
    endcase
  endfunction : rl_of

  function automatic mac_cyc_t wl_of(input logic [2:0] cfg);
    case (cfg)
      CFG_2: wl_of = 4'h8;
      CFG_3: wl_of = 4'hA;
      CFG_4: wl_of = 4'h5;
      CFG_5: wl_of = 4'h7;
      default: wl_of = 4'h6;
    endcase
  endfunction : wl_of

  function automatic int fmax_of(input logic [2:0] cfg);
    case (cfg)
      CFG_2: fmax_of = 32'h190;
      CFG_3: fmax_of = 32'h215;
      CFG_4: fmax_of = 32'hC8;
      CFG_5: fmax_of = 32'h14D;
      default: fmax_of = 32'h10A;
    endcase
  endfunction : fmax_of

  // clocks per burst, two elements per clock
  function automatic logic [2:0] beats_of(input logic [1:0] bl);
    case (bl)
      BL_4: beats_of = 3'h2;
      BL_8: beats_of = 3'h4;
      default: beats_of = 3'h1;
    endcase
  endfunction : beats_of

  function automatic logic no_bl8(input logic [2:0] cfg);
    no_bl8 = (cfg == CFG_1) || (cfg == CFG_4);
  endfunction : no_bl8

endpackage : mac_pkg

// ===== rtl/mac_link_if.sv
`timescale 1ns/1ps
interface mac_link_if #(
  parameter int AW = 11,
  parameter int DW = 9
);
  mac_pkg::mac_cmd_e cmd;
  logic [AW-1:0] addr;
  logic [mac_pkg::BANK_W-1:0] bank;
  logic [2*DW-1:0] wdata;
  logic wvalid;
  logic [2*DW-1:0] rdata;
  logic rvalid;

  modport dev (
    input cmd,
    input addr,
    input bank,
    input wdata,
    input wvalid,
    output rdata,
    output rvalid
  );

  modport ctl (
    output cmd,
    output addr,
    output bank,
    output wdata,
    output wvalid,
    input rdata,
    input rvalid
  );
endinterface : mac_link_if

// ===== rtl/mac_dev.sv
`timescale 1ns/1ps
// Function
// - multiplexed mode adds one cycle to latencies
// - row cycle unchanged by multiplexed mode
// - five configurations of row cycle and latencies
// - controller clock stays inside configuration band
// - no burst of eight in configurations one, four
// - configuration four: three cycles, four write-read
// - refresh executes on the following edge, on the second edge in multiplexed mode
// - next command allowed right after refresh
// - refresh targets only banks past row cycle
// - same-bank write again only after row cycle
// - same-bank read only after row cycle
// - same-bank write after read needs row cycle
// - burst of four: first element plus three
// - burst of two: first element plus one
// - address sent in two parts, both captured
// - mode set with bit five enters multiplexing
module mac_dev #(
  parameter int AW = 11,
  parameter int DW = 9,
  parameter int MEM_LG = 8
) (
  input wire logic clk,
  input wire logic rst,
  mac_link_if.dev link,
  output logic mux_mode,
  output logic [2:0] cfg_sel,
  output mac_pkg::mac_cyc_t row_cycle_time,
  output mac_pkg::mac_cyc_t read_latency,
  output mac_pkg::mac_cyc_t write_latency,
  output logic [2:0] burst_beats,
  output logic bl_err,
  output logic ref_pulse,
  output logic [2:0] ref_bank
);

  // ----------------------------------------------------------------
  // parameter checks
  // ----------------------------------------------------------------
  if (AW <= mac_pkg::MUX_BIT || MEM_LG < mac_pkg::BANK_W + 2 ||
      MEM_LG - mac_pkg::BANK_W > 2 * AW) begin : g_bad_param
    $error("mac_dev: unsupported address or memory width");
  end

  typedef enum logic [0:0] {
    ST_CMD = 1'h0,
    ST_PART2 = 1'h1
  } mac_dst_e;

  localparam int CW = MEM_LG - mac_pkg::BANK_W;

  mac_dst_e st_q;
  mac_pkg::mac_cmd_e cmd_q;
  logic [AW-1:0] pa_q;
  logic [2:0] ba_q;
  logic mux_q;
  logic [AW-1:0] mode_q;
  logic bl_err_q;
  logic ref_pend_q;
  logic [2:0] ref_pend_bank_q;
  logic ref_pulse_q;
  logic [2:0] ref_bank_q;

  logic ex_v;
  mac_pkg::mac_cmd_e ex_cmd;
  logic [AW-1:0] ex_a;
  logic [AW-1:0] ex_b;
  logic [2:0] ex_bank;
  logic [MEM_LG-1:0] ex_idx;
  logic ref_go;

  logic [2:0] cfg_eff;
  logic [1:0] bl_code;
  logic [2:0] beats;
  mac_pkg::mac_cyc_t rl_eff;
  mac_pkg::mac_cyc_t wl_eff;
  mac_pkg::mac_cyc_t k_r;
  mac_pkg::mac_cyc_t k_w;

  logic sv_q [mac_pkg::SLOTS];
  logic sw_q [mac_pkg::SLOTS];
  logic [MEM_LG-1:0] si_q [mac_pkg::SLOTS];

  logic bact_q;
  logic [2:0] bcnt_q;
  logic bwr_q;
  logic [MEM_LG-1:0] bidx_q;
  logic cur_v;
  logic cur_wr;
  logic [MEM_LG-1:0] cur_idx;

  logic [2*DW-1:0] mem [2**MEM_LG];
  logic rv_q;
  logic [2*DW-1:0] rd_q;

  // ----------------------------------------------------------------
  // command capture
  // ----------------------------------------------------------------
  // part capture
  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= ST_CMD;
      cmd_q <= mac_pkg::CMD_NOP;
      pa_q <= '0;
      ba_q <= '0;
    end else begin
      case (st_q)
        ST_CMD: begin
          if (mux_q && (link.cmd == mac_pkg::CMD_READ ||
              link.cmd == mac_pkg::CMD_WRITE ||
              link.cmd == mac_pkg::CMD_MRS)) begin
            st_q <= ST_PART2;
            cmd_q <= link.cmd;
            pa_q <= link.addr;
            ba_q <= link.bank;
          end
        end
        ST_PART2: st_q <= ST_CMD;
        default: st_q <= ST_CMD;
      endcase
    end
  end

  // execute now: second part in multiplexed mode, else single clock
  always_comb begin
    ex_v = 1'b0;
    ex_cmd = mac_pkg::CMD_NOP;
    ex_a = '0;
    ex_b = '0;
    ex_bank = '0;
    if (st_q == ST_PART2) begin
      ex_v = 1'b1;
      ex_cmd = cmd_q;
      ex_a = pa_q;
      ex_b = link.addr;
      ex_bank = ba_q;
    end else if (!mux_q && (link.cmd == mac_pkg::CMD_READ ||
        link.cmd == mac_pkg::CMD_WRITE ||
        link.cmd == mac_pkg::CMD_MRS)) begin
      ex_v = 1'b1;
      ex_cmd = link.cmd;
      ex_a = link.addr;
      ex_bank = link.bank;
    end
  end

  assign ex_idx = {ex_bank, CW'({ex_b, ex_a})};
  assign ref_go = (st_q == ST_CMD) && (link.cmd == mac_pkg::CMD_REF);

  // ----------------------------------------------------------------
  // mode register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      mux_q <= 1'b0;
      mode_q <= '0;
      bl_err_q <= 1'b0;
    end else if (ex_v && ex_cmd == mac_pkg::CMD_MRS) begin
      mode_q <= ex_a;
      mux_q <= ex_a[mac_pkg::MUX_BIT];
      bl_err_q <= (ex_a[mac_pkg::BL_LSB +: 2] == mac_pkg::BL_8) &&
        mac_pkg::no_bl8(ex_a[mac_pkg::CFG_LSB +: 3]);
    end
  end

  always_comb begin
    cfg_eff = mode_q[mac_pkg::CFG_LSB +: 3];
    if (cfg_eff > mac_pkg::CFG_5) begin
      cfg_eff = mac_pkg::CFG_1;
    end
    bl_code = mode_q[mac_pkg::BL_LSB +: 2];
    if (bl_code == mac_pkg::BL_8 && mac_pkg::no_bl8(cfg_eff)) begin
      bl_code = mac_pkg::BL_4;
    end
    beats = mac_pkg::beats_of(bl_code);
    rl_eff = mac_pkg::rl_of(cfg_eff) -
      (mux_q ? 4'h0 : mac_pkg::mac_cyc_t'(mac_pkg::MUX_EXTRA));
    wl_eff = mac_pkg::wl_of(cfg_eff) -
      (mux_q ? 4'h0 : mac_pkg::mac_cyc_t'(mac_pkg::MUX_EXTRA));
    k_r = rl_eff - mac_pkg::mac_cyc_t'(mac_pkg::RD_PIPE) - {3'h0, mux_q};
    k_w = wl_eff - mac_pkg::mac_cyc_t'(mac_pkg::WR_PIPE) - {3'h0, mux_q};
  end

  assign cfg_sel = cfg_eff;
  assign mux_mode = mux_q;
  assign row_cycle_time = mac_pkg::trc_of(cfg_eff);
  assign read_latency = rl_eff;
  assign write_latency = wl_eff;
  assign burst_beats = beats;
  assign bl_err = bl_err_q;

  // ----------------------------------------------------------------
  // bank refresh
  // ----------------------------------------------------------------
  // refresh one edge later, two edges later in multiplexed mode
  always_ff @(posedge clk) begin
    if (rst) begin
      ref_pend_q <= 1'b0;
      ref_pend_bank_q <= '0;
      ref_pulse_q <= 1'b0;
      ref_bank_q <= '0;
    end else begin
      ref_pend_q <= ref_go && mux_q;
      ref_pend_bank_q <= link.bank;
      ref_pulse_q <= ref_pend_q || (ref_go && !mux_q);
      ref_bank_q <= ref_pend_q ? ref_pend_bank_q : link.bank;
    end
  end

  assign ref_pulse = ref_pulse_q;
  assign ref_bank = ref_bank_q;

  // ----------------------------------------------------------------
  // latency delay line
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < mac_pkg::SLOTS; i++) begin
        sv_q[i] <= 1'b0;
        sw_q[i] <= 1'b0;
        si_q[i] <= '0;
      end
    end else begin
      for (int i = 0; i < mac_pkg::SLOTS - 1; i++) begin
        sv_q[i] <= sv_q[i+1];
        sw_q[i] <= sw_q[i+1];
        si_q[i] <= si_q[i+1];
      end
      sv_q[mac_pkg::SLOTS-1] <= 1'b0;
      sw_q[mac_pkg::SLOTS-1] <= 1'b0;
      si_q[mac_pkg::SLOTS-1] <= '0;
      if (ex_v && ex_cmd == mac_pkg::CMD_READ) begin
        sv_q[k_r] <= 1'b1;
        sw_q[k_r] <= 1'b0;
        si_q[k_r] <= ex_idx;
      end
      if (ex_v && ex_cmd == mac_pkg::CMD_WRITE) begin
        sv_q[k_w] <= 1'b1;
        sw_q[k_w] <= 1'b1;
        si_q[k_w] <= ex_idx;
      end
    end
  end

  // ----------------------------------------------------------------
  // burst engine, two elements per clock
  // ----------------------------------------------------------------
  assign cur_v = sv_q[0] || bact_q;
  assign cur_wr = sv_q[0] ? sw_q[0] : bwr_q;
  assign cur_idx = sv_q[0] ? si_q[0] : bidx_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      bact_q <= 1'b0;
      bcnt_q <= '0;
      bwr_q <= 1'b0;
      bidx_q <= '0;
    end else if (sv_q[0]) begin
      bact_q <= beats > 3'h1;
      bcnt_q <= beats - 3'h1;
      bwr_q <= sw_q[0];
      bidx_q <= si_q[0] + 1'b1;
    end else if (bact_q) begin
      bact_q <= bcnt_q != 3'h1;
      bcnt_q <= bcnt_q - 3'h1;
      bidx_q <= bidx_q + 1'b1;
    end
  end

  // wvalid clear masks the beat
  always_ff @(posedge clk) begin
    if (cur_v && cur_wr && link.wvalid) begin
      mem[cur_idx] <= link.wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rv_q <= 1'b0;
      rd_q <= '0;
    end else begin
      rv_q <= cur_v && !cur_wr;
      rd_q <= (cur_v && !cur_wr) ? mem[cur_idx] : '0;
    end
  end

  assign link.rdata = rd_q;
  assign link.rvalid = rv_q;

endmodule : mac_dev

// ===== rtl/mac_ctl.sv
// Design decisions made here: the address map, the write queue and the response buffer.
`timescale 1ns/1ps
module mac_ctl #(
  parameter int AW = 11,
  parameter int DW = 9,
  parameter logic [2:0] CFG = mac_pkg::CFG_3,
  parameter logic [1:0] BL = mac_pkg::BL_4,
  parameter int CLK_MHZ = 200,
  parameter int MRSC_CYC = 6,
  parameter int WQ_DEPTH = 4
) (
  input wire logic clk,
  input wire logic rst,
  mac_link_if.ctl link,
  output logic init_done,
  input wire logic req_valid,
  output logic req_ready,
  input wire mac_pkg::mac_cmd_e req_op,
  input wire logic [2:0] req_bank,
  input wire logic [2*AW-1:0] req_addr,
  input wire logic [mac_pkg::MAX_BEATS*2*DW-1:0] req_wdata,
  output logic rsp_valid,
  input wire logic rsp_ready,
  output logic [mac_pkg::MAX_BEATS*2*DW-1:0] rsp_data
);

  // ----------------------------------------------------------------
  // parameter checks
  // ----------------------------------------------------------------
  // refuse long burst
  if (CFG > mac_pkg::CFG_5 || MRSC_CYC < 1 || MRSC_CYC > 255 ||
      WQ_DEPTH < 2 || (WQ_DEPTH & (WQ_DEPTH - 1)) != 0 ||
      AW <= mac_pkg::MUX_BIT ||
      (BL == mac_pkg::BL_8 && mac_pkg::no_bl8(CFG))) begin : g_bad_param
    $error("mac_ctl: unsupported parameter value");
  end
  if (CLK_MHZ < mac_pkg::FREQ_MIN_MHZ ||
      CLK_MHZ > mac_pkg::fmax_of(CFG)) begin : g_bad_clock
    $error("mac_ctl: clock outside configuration band");
  end

  typedef enum logic [2:0] {
    C_ENTER = 3'h0,
    C_WAIT = 3'h1,
    C_MRS = 3'h2,
    C_SEC = 3'h3,
    C_IDLE = 3'h4
  } mac_cst_e;

  localparam int BW = 2 * DW;
  localparam int QW = $clog2(WQ_DEPTH);
  localparam mac_pkg::mac_cyc_t ROW_CYCLE_TIME = mac_pkg::trc_of(CFG);
  localparam mac_pkg::mac_cyc_t WSLOT =
    mac_pkg::wl_of(CFG) - mac_pkg::mac_cyc_t'(mac_pkg::WR_PIPE);
  localparam logic [1:0] LAST = 2'(mac_pkg::beats_of(BL) - 3'h1);
  localparam logic CFG4 = (CFG == mac_pkg::CFG_4);

  mac_cst_e st_q;
  logic [7:0] wait_q;
  logic init_q;
  mac_pkg::mac_cmd_e cmd_q;
  logic [AW-1:0] addr_q;
  logic [AW-1:0] pb_q;
  logic [2:0] bank_q;
  logic [AW-1:0] mode_w;
  logic go;
  logic bank_ok;
  logic rd_room;

  logic [3:0] cnt_q [mac_pkg::BANKS];
  logic wr_q [mac_pkg::BANKS];

  logic [mac_pkg::MAX_BEATS*BW-1:0] wq_q [WQ_DEPTH];
  logic [QW-1:0] wq_wp_q;
  logic [QW-1:0] wq_rp_q;
  logic [QW:0] wq_cnt_q;
  logic ws_q [mac_pkg::SLOTS];
  logic wact_q;
  logic [1:0] wbeat_q;
  logic wcur;
  logic [1:0] wcb;
  logic wpop;
  logic wpush;
  logic [BW-1:0] wdata_q;
  logic wvalid_q;

  logic [1:0] rb_q;
  logic [mac_pkg::MAX_BEATS*BW-1:0] asm_q;
  logic [mac_pkg::MAX_BEATS*BW-1:0] asm_n;
  logic rdone;
  logic [1:0] rd_out_q;
  logic [mac_pkg::MAX_BEATS*BW-1:0] rbuf_q [mac_pkg::RSP_DEPTH];
  logic rwp_q;
  logic rrp_q;
  logic [1:0] rcnt_q;
  logic rpop;

  always_comb begin
    mode_w = '0;
    mode_w[mac_pkg::CFG_LSB +: 3] = CFG;
    mode_w[mac_pkg::BL_LSB +: 2] = BL;
    mode_w[mac_pkg::MUX_BIT] = 1'b1;
  end

  // ----------------------------------------------------------------
  // issue gating
  // ----------------------------------------------------------------
  // bank reuse
  assign bank_ok = cnt_q[req_bank] <=
    {3'h0, req_op != mac_pkg::CMD_READ && wr_q[req_bank]};
  // read credit keeps the response buffer from overflowing
  assign rd_room = ({1'b0, rd_out_q} + {1'b0, rcnt_q}) <
    3'(mac_pkg::RSP_DEPTH);
  assign req_ready = (st_q == C_IDLE) && bank_ok &&
    (req_op != mac_pkg::CMD_READ || rd_room) &&
    (req_op != mac_pkg::CMD_WRITE || wq_cnt_q < (QW+1)'(WQ_DEPTH));
  assign go = req_valid && req_ready;
  assign wpush = go && req_op == mac_pkg::CMD_WRITE;

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= C_ENTER;
      wait_q <= '0;
      init_q <= 1'b0;
      cmd_q <= mac_pkg::CMD_NOP;
      addr_q <= '0;
      pb_q <= '0;
      bank_q <= '0;
    end else begin
      cmd_q <= mac_pkg::CMD_NOP;
      case (st_q)
        C_ENTER: begin
          cmd_q <= mac_pkg::CMD_MRS;
          addr_q <= mode_w;
          wait_q <= 8'(MRSC_CYC - 1);
          st_q <= C_WAIT;
        end
        C_WAIT: begin
          wait_q <= wait_q - 8'h01;
          if (wait_q == 8'h00) begin
            st_q <= C_MRS;
          end
        end
        C_MRS: begin
          cmd_q <= mac_pkg::CMD_MRS;
          addr_q <= mode_w;
          pb_q <= '0;
          st_q <= C_SEC;
        end
        C_SEC: begin
          addr_q <= pb_q;
          init_q <= 1'b1;
          st_q <= C_IDLE;
        end
        C_IDLE: begin
          if (go && (req_op == mac_pkg::CMD_READ ||
              req_op == mac_pkg::CMD_WRITE ||
              req_op == mac_pkg::CMD_REF)) begin
            cmd_q <= req_op;
            addr_q <= req_addr[AW-1:0];
            pb_q <= req_addr[2*AW-1:AW];
            bank_q <= req_bank;
            st_q <= (req_op == mac_pkg::CMD_REF) ? C_IDLE : C_SEC;
          end
        end
        default: st_q <= C_ENTER;
      endcase
    end
  end

  assign link.cmd = cmd_q;
  assign link.addr = addr_q;
  assign link.bank = bank_q;
  assign init_done = init_q;

  always_ff @(posedge clk) begin
    for (int b = 0; b < mac_pkg::BANKS; b++) begin
      if (rst) begin
        cnt_q[b] <= '0;
        wr_q[b] <= 1'b0;
      end else if (go && st_q == C_IDLE && req_bank == 3'(b) &&
          req_op != mac_pkg::CMD_NOP && req_op != mac_pkg::CMD_MRS) begin
        cnt_q[b] <= ROW_CYCLE_TIME - 4'h1 +
          {3'h0, CFG4 && req_op == mac_pkg::CMD_WRITE};
        wr_q[b] <= CFG4 && req_op == mac_pkg::CMD_WRITE;
      end else if (cnt_q[b] != 4'h0) begin
        cnt_q[b] <= cnt_q[b] - 4'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // write data path
  // ----------------------------------------------------------------
  assign wcur = ws_q[0] || wact_q;
  assign wcb = ws_q[0] ? 2'h0 : wbeat_q;
  assign wpop = wcur && wcb == LAST;

  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < mac_pkg::SLOTS; i++) begin
        ws_q[i] <= 1'b0;
      end
    end else begin
      for (int i = 0; i < mac_pkg::SLOTS - 1; i++) begin
        ws_q[i] <= ws_q[i+1];
      end
      ws_q[mac_pkg::SLOTS-1] <= 1'b0;
      if (wpush) begin
        ws_q[WSLOT] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (wpush) begin
      wq_q[wq_wp_q] <= req_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wq_wp_q <= '0;
      wq_rp_q <= '0;
      wq_cnt_q <= '0;
      wact_q <= 1'b0;
      wbeat_q <= '0;
      wdata_q <= '0;
      wvalid_q <= 1'b0;
    end else begin
      wq_wp_q <= wq_wp_q + QW'(wpush);
      wq_rp_q <= wq_rp_q + QW'(wpop);
      wq_cnt_q <= wq_cnt_q + (QW+1)'(wpush) - (QW+1)'(wpop);
      wact_q <= wcur && wcb != LAST;
      wbeat_q <= wcb + 2'h1;
      wvalid_q <= wcur;
      wdata_q <= wcur ? wq_q[wq_rp_q][wcb*BW +: BW] : '0;
    end
  end

  assign link.wdata = wdata_q;
  assign link.wvalid = wvalid_q;

  // ----------------------------------------------------------------
  // read data path and response buffer
  // ----------------------------------------------------------------
  always_comb begin
    asm_n = asm_q;
    asm_n[rb_q*BW +: BW] = link.rdata;
  end

  assign rdone = link.rvalid && rb_q == LAST;
  assign rpop = rsp_valid && rsp_ready;

  always_ff @(posedge clk) begin
    if (rst) begin
      rb_q <= '0;
      asm_q <= '0;
      rd_out_q <= '0;
    end else begin
      if (link.rvalid) begin
        asm_q <= asm_n;
        rb_q <= rdone ? 2'h0 : rb_q + 2'h1;
      end
      rd_out_q <= rd_out_q + 2'(go && req_op == mac_pkg::CMD_READ) -
        2'(rdone);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rwp_q <= 1'b0;
      rrp_q <= 1'b0;
      rcnt_q <= '0;
      for (int i = 0; i < mac_pkg::RSP_DEPTH; i++) begin
        rbuf_q[i] <= '0;
      end
    end else begin
      if (rdone) begin
        rbuf_q[rwp_q] <= asm_n;
      end
      rwp_q <= rwp_q ^ rdone;
      rrp_q <= rrp_q ^ rpop;
      rcnt_q <= rcnt_q + 2'(rdone) - 2'(rpop);
    end
  end

  assign rsp_valid = rcnt_q != 2'h0;
  assign rsp_data = rbuf_q[rrp_q];

endmodule : mac_ctl

// ===== bench/mac_monitor.sv
`timescale 1ns/1ps
module mac_monitor #(
  parameter int AW = 11,
  parameter int DW = 9
) (
  input wire logic clk,
  input wire logic rst,
  input wire mac_pkg::mac_cmd_e cmd,
  input wire logic [AW-1:0] addr,
  input wire logic [2:0] bank,
  input wire logic [2*DW-1:0] wdata,
  input wire logic wvalid,
  input wire logic [2*DW-1:0] rdata,
  input wire logic rvalid
);
  default clocking
    @(posedge clk);
  endclocking
  default disable iff (rst);
  // ----------------------------------------------------------------
  // bursts not followed by a like command
  // ----------------------------------------------------------------
  sequence s_rd_alone;
    cmd == mac_pkg::CMD_READ ##2 cmd != mac_pkg::CMD_READ;
  endsequence
  sequence s_wr_alone;
    cmd == mac_pkg::CMD_WRITE ##2 cmd != mac_pkg::CMD_WRITE;
  endsequence
  a_rd_latency: assert property (
    cmd == mac_pkg::CMD_READ |-> ##9 rvalid) else $error("read late");
  a_wr_latency: assert property (
    cmd == mac_pkg::CMD_WRITE |-> ##10 wvalid) else $error("write late");
  a_rd_cause: assert property (
    $rose(rvalid) |-> $past(cmd, 9) == mac_pkg::CMD_READ)
    else $error("read data without read");
  a_rd_burst: assert property (
    s_rd_alone |-> ##7 rvalid [*2] ##1 !rvalid) else $error("read burst");
  a_wr_burst: assert property (
    s_wr_alone |-> ##8 wvalid [*2] ##1 !wvalid) else $error("write burst");
  a_second_part: assert property (
    cmd inside {mac_pkg::CMD_READ, mac_pkg::CMD_WRITE, mac_pkg::CMD_MRS}
    |=> cmd == mac_pkg::CMD_NOP) else $error("command in second part");
  a_rdata_idle: assert property (
    !rvalid |-> rdata == '0) else $error("read data without valid");
  a_rst_quiet: assert property (
    $fell(rst) |-> cmd == mac_pkg::CMD_NOP && !rvalid && !wvalid)
    else $error("link busy after reset");
endmodule : mac_monitor

// ===== bench/tb.sv
`timescale 1ns/1ps
module tb;
  logic clk;
  logic rst;
  logic init_done, req_valid, req_ready, rsp_valid, rsp_ready;
  mac_pkg::mac_cmd_e req_op;
  logic [2:0] req_bank, cfg_sel, burst_beats, ref_bank;
  logic [21:0] req_addr;
  logic [71:0] req_wdata, rsp_data;
  logic mux_mode, bl_err, ref_pulse;
  mac_pkg::mac_cyc_t row_cycle_time, read_latency, write_latency;
  int err_count = 0;
  int checks_done = 0;
  mac_link_if mac_link_if_inst ();
  mac_dev mac_dev_inst (.clk(clk), .rst(rst), .link(mac_link_if_inst),
    .mux_mode(mux_mode), .cfg_sel(cfg_sel), .row_cycle_time(row_cycle_time),
    .read_latency(read_latency), .write_latency(write_latency),
    .burst_beats(burst_beats), .bl_err(bl_err), .ref_pulse(ref_pulse),
    .ref_bank(ref_bank));
  mac_ctl mac_ctl_inst (.clk(clk), .rst(rst), .link(mac_link_if_inst),
    .init_done(init_done), .req_valid(req_valid), .req_ready(req_ready),
    .req_op(req_op), .req_bank(req_bank), .req_addr(req_addr),
    .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready),
    .rsp_data(rsp_data));
  mac_monitor mac_monitor_inst (.clk(clk), .rst(rst),
    .cmd(mac_link_if_inst.cmd), .addr(mac_link_if_inst.addr),
    .bank(mac_link_if_inst.bank), .wdata(mac_link_if_inst.wdata),
    .wvalid(mac_link_if_inst.wvalid), .rdata(mac_link_if_inst.rdata),
    .rvalid(mac_link_if_inst.rvalid));
  initial begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic test_done;
    $display("errors %0d checks %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : test_done
  task automatic chk(input string nm, input logic [35:0] seen, want);
    checks_done++;
    if (seen !== want) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, want, seen);
    end
  endtask : chk
  task automatic wait_hi(ref logic s);
    int n;
    n = 0;
    while (s !== 1'h1 && n < 300) begin
      @(negedge clk);
      n++;
    end
    if (n >= 300) begin
      err_count++;
      test_done();
    end
  endtask : wait_hi
  // start just after a rising edge, else the request is taken twice;
  // request stays valid on return; the caller lowers it
  task automatic req(input mac_pkg::mac_cmd_e op, input logic [2:0] b,
                     input logic [35:0] d);
    req_op <= op;
    req_bank <= b;
    req_addr <= {11'h2A5, 8'h0, b};
    req_wdata <= {36'h0, d};
    req_valid <= 1'h1;
    @(negedge clk);
    wait_hi(req_ready);
    @(posedge clk);
  endtask : req
  task automatic drain(input logic [35:0] want);
    @(negedge clk);
    wait_hi(rsp_valid);
    chk("rsp_data", rsp_data[35:0], want);
    @(posedge clk);
    rsp_ready <= 1'h1;
    @(posedge clk);
    rsp_ready <= 1'h0;
  endtask : drain
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_init;
    wait_hi(init_done);
    chk("mux_mode", mux_mode, 36'h1);
    chk("cfg_sel", cfg_sel, mac_pkg::CFG_3);
    chk("read_latency", read_latency, 36'h9);
    chk("write_latency", write_latency, 36'hA);
    chk("row_cycle_time", row_cycle_time, 36'h8);
    chk("burst_beats", burst_beats, 36'h2);
    chk("bl_err", bl_err, 36'h0);
    @(posedge clk);
  endtask : t_init
  task automatic t_refresh;
    req(mac_pkg::CMD_REF, 3'h1, 36'h0);
    req(mac_pkg::CMD_REF, 3'h2, 36'h0);
    req_valid <= 1'h0;
    @(negedge clk);
    wait_hi(ref_pulse);
    chk("ref_bank", ref_bank, 36'h1);
    @(negedge clk);
    chk("ref_pulse", ref_pulse, 36'h1);
    chk("ref_bank", ref_bank, 36'h2);
    @(posedge clk);
  endtask : t_refresh
  // reads pile up in the buffer while the user stalls
  task automatic t_stream;
    int n;
    int beats;
    n = 0;
    beats = 0;
    req(mac_pkg::CMD_WRITE, 3'h4, 36'h9_1234_5678);
    req(mac_pkg::CMD_WRITE, 3'h5, 36'h6_EDCB_A987);
    req(mac_pkg::CMD_READ, 3'h4, 36'h0);
    req(mac_pkg::CMD_READ, 3'h5, 36'h0);
    req_valid <= 1'h0;
    while (beats < 4 && n < 300) begin
      @(negedge clk);
      beats += int'(mac_link_if_inst.rvalid === 1'h1);
      n++;
    end
    chk("read_beats", 36'(beats), 36'h4);
    drain(36'h9_1234_5678);
    drain(36'h6_EDCB_A987);
  endtask : t_stream
  initial begin
    rst = 1'h1;
    req_valid = 1'h0;
    rsp_ready = 1'h0;
    req_op = mac_pkg::CMD_NOP;
    req_bank = 3'h0;
    req_addr = 22'h0;
    req_wdata = 72'h0;
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    t_init();
    t_refresh();
    t_stream();
    test_done();
  end
endmodule : tb
